// ---- core/mio_cfgmem.v ----
// non-volatile configuration store with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "mio_map.vh"
module mio_cfgmem #(
    parameter DW = 16,
    parameter AW = 1
) (
    input wire hclk,
    input wire hresetn,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata_ff
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer i;

    // contents survive hresetn; power-up image is the built-in default
    initial
    begin
        for (i = 0; i < (1<<AW); i = i + 1)
            mem[i] = {DW{1'b0}};
        mem[`MIO_MEM_CFG] = `MIO_CFG_DEFAULT;
        mem[`MIO_MEM_PMSK] = `MIO_PMSK_DEFAULT;
    end

    always @(posedge hclk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_ff <= {DW{1'b0}};
        else
            rdata_ff <= mem[raddr];
    end
endmodule
`default_nettype wire

// ---- core/mio_quad.v ----
// quadrature decoder and up/down handwheel counter
`timescale 1ns/100ps
`default_nettype none
`include "mio_map.vh"
module mio_quad #(
    parameter CW = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire clr,
    input wire en,
    input wire fine,
    input wire ph_a,
    input wire ph_b,
    output reg [CW-1:0] count_ff,
    output reg changed_ff
);
    reg [1:0] prev_ff;
    reg [4:0] acc_ff;
    reg up_ff;
    reg [1:0] cur;
    reg step;
    reg dir_up;
    reg [4:0] lim;
    reg [4:0] nxt_acc;
    reg [CW-1:0] nxt_count;
    reg nxt_up;

    always @*
    begin
        cur = {ph_a, ph_b};
        lim = fine ? `MIO_EDGES_FINE : `MIO_EDGES_COARSE;
        // gray sequence 00-01-11-10 counts up
        step = (cur != prev_ff) && ((cur ^ prev_ff) != 2'b11);
        dir_up = (cur[1] ^ prev_ff[0]) == 1'b0;
        nxt_acc = acc_ff;
        nxt_count = count_ff;
        nxt_up = up_ff;
        if (en && step)
        begin
            // reversal restarts the partial count so lim edges (4 fine, 16 coarse) in one direction make one count
            if (dir_up != up_ff)
                nxt_acc = 5'd1;
            else
                nxt_acc = acc_ff + 5'd1;
            nxt_up = dir_up;
            if (nxt_acc == lim)
            begin
                nxt_acc = 5'd0;
                nxt_count = dir_up ? count_ff + 1'b1 : count_ff - 1'b1;
            end
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_ff <= 2'b00;
            acc_ff <= 5'd0;
            up_ff <= 1'b1;
            count_ff <= {CW{1'b0}};
            changed_ff <= 1'b0;
        end
        else if (clr)
        begin
            prev_ff <= {ph_a, ph_b};
            acc_ff <= 5'd0;
            up_ff <= 1'b1;
            count_ff <= {CW{1'b0}};
            changed_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= cur;
            acc_ff <= nxt_acc;
            up_ff <= nxt_up;
            count_ff <= nxt_count;
            changed_ff <= (nxt_count != count_ff);
        end
    end
endmodule
`default_nettype wire

// ---- core/mio_top.v ----
// serial I/O unit core: discrete I/O, handwheels, output guard, spindle PWM, analog registers
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mio_map.vh"
module mio_top #(
    parameter [31:0] PUMP_BASE_CYC = `MIO_PUMP_BASE_US * `MIO_CLK_MHZ,
    parameter CW = 16,
    parameter AINW = 10
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout_ff,
    output reg hresp_ff,
    output reg [31:0] hrdata_ff,
    input wire [7:0] din,
    input wire [AINW-1:0] analog_in_first,
    input wire [AINW-1:0] analog_in_second,
    input wire [AINW-1:0] analog_in_third,
    input wire [3:0] cfg_sel,
    output reg [7:0] dout_ff,
    output reg irq_ff
);
    localparam LD_START = 2'd0;
    localparam LD_CFG = 2'd1;
    localparam LD_MSK = 2'd2;
    localparam LD_RUN = 2'd3;

    // pin synchronisers
    reg [7:0] din_m_ff, din_s_ff, din_d_ff;
    reg [AINW-1:0] ain1_m_ff, ain1_s_ff;
    reg [AINW-1:0] ain2_m_ff, ain2_s_ff;
    reg [AINW-1:0] ain3_m_ff, ain3_s_ff;
    reg [3:0] sel_m_ff, sel_s_ff;

    // bus and register state
    reg wr_pend_ff;
    reg [`MIO_IDX_W-1:0] wr_idx_ff;
    reg [7:0] host_out_ff;
    reg [AINW-1:0] spd_ff, spdmax_ff;
    reg spd_dir_ff;
    reg [`MIO_EV_W-1:0] stat_ff, mask_ff;
    reg [15:0] stored_cfg_ff, stored_msk_ff;
    reg [15:0] act_cfg_ff, act_msk_ff;
    reg [1:0] ld_state_ff;
    reg [31:0] pump_cnt_ff;
    reg pump_lost_ff;
    reg [AINW-1:0] pwm_cnt_ff;

    wire [15:0] mem_rdata;
    wire [CW-1:0] hw0_count, hw1_count;
    wire hw0_chg, hw1_chg;

    wire acc = hsel & htrans[1] & hready;
    wire [`MIO_IDX_W-1:0] a_idx = haddr[`MIO_IDX_W+1:2];
    wire wr_now = wr_pend_ff;
    wire wr_cfg = wr_now && (wr_idx_ff == `MIO_IDX_CFG);
    wire wr_pmsk = wr_now && (wr_idx_ff == `MIO_IDX_PMSK);
    wire wr_ctrl = wr_now && (wr_idx_ff == `MIO_IDX_CTRL);
    wire soft_rst = wr_ctrl && hwdata[`MIO_CTRL_RESET];
    wire running = (ld_state_ff == LD_RUN);
    wire rd_stat = acc && !hwrite && (a_idx == `MIO_IDX_STAT);

    wire pump_en = act_cfg_ff[`MIO_CFG_PUMP_EN];
    wire [2:0] dly_code = act_cfg_ff[`MIO_CFG_DLY_HI:`MIO_CFG_DLY_LO];
    wire spin_en = act_cfg_ff[`MIO_CFG_SPIN_EN];
    wire spin_dir_use = act_cfg_ff[`MIO_CFG_SPIN_DIR];
    wire ain_en = act_cfg_ff[`MIO_CFG_AIN_EN];
    wire [31:0] pump_lim = ({29'd0, dly_code} + 32'd1) * PUMP_BASE_CYC;
    wire pump_kick = (wr_now && (wr_idx_ff == `MIO_IDX_DOUT))
        || (wr_ctrl && hwdata[`MIO_CTRL_KICK]);

    // configuration store
    mio_cfgmem #(
        .DW(16),
        .AW(1)
    ) u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(wr_cfg | wr_pmsk),
        .waddr(wr_cfg ? `MIO_MEM_CFG : `MIO_MEM_PMSK),
        .wdata(hwdata[15:0]),
        .raddr(ld_state_ff == LD_START ? `MIO_MEM_CFG : `MIO_MEM_PMSK),
        .rdata_ff(mem_rdata)
    );

    // handwheel counters
    mio_quad #(
        .CW(CW)
    ) u_hw0 (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(soft_rst),
        .en(running & act_cfg_ff[`MIO_CFG_HW0_EN]),
        .fine(act_cfg_ff[`MIO_CFG_HW_FINE]),
        .ph_a(din_s_ff[`MIO_HW0_A]),
        .ph_b(din_s_ff[`MIO_HW0_B]),
        .count_ff(hw0_count),
        .changed_ff(hw0_chg)
    );

    mio_quad #(
        .CW(CW)
    ) u_hw1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(soft_rst),
        .en(running & act_cfg_ff[`MIO_CFG_HW1_EN]),
        .fine(act_cfg_ff[`MIO_CFG_HW_FINE]),
        .ph_a(din_s_ff[`MIO_HW1_A]),
        .ph_b(din_s_ff[`MIO_HW1_B]),
        .count_ff(hw1_count),
        .changed_ff(hw1_chg)
    );

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            din_m_ff <= 8'h00;
            din_s_ff <= 8'h00;
            din_d_ff <= 8'h00;
            ain1_m_ff <= {AINW{1'b0}};
            ain1_s_ff <= {AINW{1'b0}};
            ain2_m_ff <= {AINW{1'b0}};
            ain2_s_ff <= {AINW{1'b0}};
            ain3_m_ff <= {AINW{1'b0}};
            ain3_s_ff <= {AINW{1'b0}};
            sel_m_ff <= 4'h0;
            sel_s_ff <= 4'h0;
        end
        else
        begin
            din_m_ff <= din;
            din_s_ff <= din_m_ff;
            din_d_ff <= din_s_ff;
            ain1_m_ff <= analog_in_first;
            ain1_s_ff <= ain1_m_ff;
            ain2_m_ff <= analog_in_second;
            ain2_s_ff <= ain2_m_ff;
            ain3_m_ff <= analog_in_third;
            ain3_s_ff <= ain3_m_ff;
            sel_m_ff <= cfg_sel;
            sel_s_ff <= sel_m_ff;
        end
    end

    // configuration load after reset; the active copy changes only here
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ld_state_ff <= LD_START;
            act_cfg_ff <= `MIO_CFG_DEFAULT;
            act_msk_ff <= `MIO_PMSK_DEFAULT;
            stored_cfg_ff <= 16'h0000;
            stored_msk_ff <= 16'h0000;
        end
        else
        begin
            if (wr_cfg)
                stored_cfg_ff <= hwdata[15:0];
            if (wr_pmsk)
                stored_msk_ff <= hwdata[15:0];
            if (soft_rst)
                ld_state_ff <= LD_START;
            else
            begin
                case (ld_state_ff)
                    LD_START:
                        ld_state_ff <= LD_CFG;
                    LD_CFG:
                    begin
                        if (!wr_cfg)
                            stored_cfg_ff <= mem_rdata;
                        if (sel_s_ff == `MIO_SEL_DEFAULT)
                            act_cfg_ff <= `MIO_CFG_DEFAULT;
                        else
                            act_cfg_ff <= mem_rdata;
                        ld_state_ff <= LD_MSK;
                    end
                    LD_MSK:
                    begin
                        if (!wr_pmsk)
                            stored_msk_ff <= mem_rdata;
                        if (sel_s_ff == `MIO_SEL_DEFAULT)
                            act_msk_ff <= `MIO_PMSK_DEFAULT;
                        else
                            act_msk_ff <= mem_rdata;
                        ld_state_ff <= LD_RUN;
                    end
                    LD_RUN:
                        ld_state_ff <= LD_RUN;
                    default:
                        ld_state_ff <= LD_START;
                endcase
            end
        end
    end

    // host register writes, charge-pump watchdog, PWM
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= {`MIO_IDX_W{1'b0}};
            host_out_ff <= 8'h00;
            spd_ff <= {AINW{1'b0}};
            spdmax_ff <= {AINW{1'b0}};
            spd_dir_ff <= 1'b0;
            mask_ff <= {`MIO_EV_W{1'b0}};
            pump_cnt_ff <= 32'd0;
            pump_lost_ff <= 1'b0;
            pwm_cnt_ff <= {AINW{1'b0}};
        end
        else
        begin
            wr_pend_ff <= acc & hwrite;
            if (acc)
                wr_idx_ff <= a_idx;
            if (soft_rst)
                host_out_ff <= 8'h00;
            else if (wr_now && (wr_idx_ff == `MIO_IDX_DOUT))
                host_out_ff <= hwdata[7:0];
            if (wr_now && (wr_idx_ff == `MIO_IDX_SPD))
            begin
                spd_ff <= hwdata[AINW-1:0];
                spd_dir_ff <= hwdata[`MIO_SPD_DIR];
            end
            if (wr_now && (wr_idx_ff == `MIO_IDX_SPDMAX))
                spdmax_ff <= hwdata[AINW-1:0];
            if (wr_now && (wr_idx_ff == `MIO_IDX_MASK))
                mask_ff <= hwdata[`MIO_EV_W-1:0];
            // loss of contact: no output write or kick within the coded delay
            if (pump_kick || soft_rst || !running)
            begin
                pump_cnt_ff <= 32'd0;
                pump_lost_ff <= 1'b0;
            end
            else if (pump_cnt_ff >= pump_lim - 32'd1)
                pump_lost_ff <= 1'b1;
            else
                pump_cnt_ff <= pump_cnt_ff + 32'd1;
            if ((pwm_cnt_ff + 1'b1) >= spdmax_ff)
                pwm_cnt_ff <= {AINW{1'b0}};
            else
                pwm_cnt_ff <= pwm_cnt_ff + 1'b1;
        end
    end

    // output gating
    reg [7:0] nxt_dout;
    reg pwm_hi;
    always @*
    begin
        pwm_hi = (spdmax_ff != {AINW{1'b0}}) &&
            ((spd_ff >= spdmax_ff) || (pwm_cnt_ff < spd_ff));
        nxt_dout = host_out_ff;
        if (spin_en)
        begin
            nxt_dout[`MIO_OUT_PWM] = pwm_hi;
            nxt_dout[`MIO_OUT_RUN] = (spd_ff != {AINW{1'b0}});
            if (spin_dir_use)
                nxt_dout[`MIO_OUT_SPIN_DIR] = spd_dir_ff;
        end
        if (pump_en && pump_lost_ff)
            nxt_dout = nxt_dout & act_msk_ff[7:0];
        if (act_cfg_ff[`MIO_CFG_DEBUG] || !running)
            nxt_dout = 8'h00;
    end

    // interrupt events; a read of the status register clears what it returned
    reg [`MIO_EV_W-1:0] ev;
    reg [`MIO_EV_W-1:0] nxt_stat;
    always @*
    begin
        ev = {`MIO_EV_W{1'b0}};
        ev[`MIO_EV_DIN] = running && (din_s_ff != din_d_ff);
        ev[`MIO_EV_PUMP] = pump_en && (pump_cnt_ff == pump_lim - 32'd1) && !pump_lost_ff
            && !pump_kick && running;
        ev[`MIO_EV_HW0] = hw0_chg;
        ev[`MIO_EV_HW1] = hw1_chg;
        ev[`MIO_EV_CFG] = wr_cfg | wr_pmsk;
        nxt_stat = (rd_stat ? {`MIO_EV_W{1'b0}} : stat_ff) | ev;
    end

    // read data for the address phase being accepted
    reg [31:0] rd_val;
    always @*
    begin
        rd_val = 32'h0000_0000;
        case (a_idx)
            `MIO_IDX_DIN: rd_val[7:0] = din_s_ff;
            `MIO_IDX_DOUT: rd_val[7:0] = host_out_ff;
            `MIO_IDX_HW0: rd_val[CW-1:0] = hw0_count;
            `MIO_IDX_HW1: rd_val[CW-1:0] = hw1_count;
            `MIO_IDX_SPD:
            begin
                rd_val[AINW-1:0] = spd_ff;
                rd_val[`MIO_SPD_DIR] = spd_dir_ff;
            end
            `MIO_IDX_SPDMAX: rd_val[AINW-1:0] = spdmax_ff;
            `MIO_IDX_STAT: rd_val[`MIO_EV_W-1:0] = stat_ff;
            `MIO_IDX_MASK: rd_val[`MIO_EV_W-1:0] = mask_ff;
            `MIO_IDX_CTRL: rd_val[`MIO_CTRL_KICK] = pump_lost_ff;
            `MIO_IDX_AIN1: rd_val[AINW-1:0] = ain_en ? ain1_s_ff : {AINW{1'b0}};
            `MIO_IDX_AIN2: rd_val[AINW-1:0] = ain_en ? ain2_s_ff : {AINW{1'b0}};
            `MIO_IDX_AIN3: rd_val[AINW-1:0] = ain_en ? ain3_s_ff : {AINW{1'b0}};
            `MIO_IDX_CFG: rd_val[15:0] = stored_cfg_ff;
            `MIO_IDX_PMSK: rd_val[15:0] = stored_msk_ff;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
            stat_ff <= {`MIO_EV_W{1'b0}};
            irq_ff <= 1'b0;
            dout_ff <= 8'h00;
        end
        else
        begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            if (acc && !hwrite)
                hrdata_ff <= rd_val;
            stat_ff <= nxt_stat;
            irq_ff <= |(nxt_stat & mask_ff);
            dout_ff <= nxt_dout;
        end
    end
endmodule
`default_nettype wire

// ---- pkg/mio_map.vh ----
// register map, field positions, defaults and timing constants of the serial I/O unit
`ifndef MIO_MAP_VH
`define MIO_MAP_VH

// register indices; byte address is four times the index
`define MIO_IDX_W 10
`define MIO_IDX_DIN 10'd0
`define MIO_IDX_DOUT 10'd1
`define MIO_IDX_HW0 10'd2
`define MIO_IDX_HW1 10'd3
`define MIO_IDX_SPD 10'd4
`define MIO_IDX_SPDMAX 10'd5
`define MIO_IDX_STAT 10'd6
`define MIO_IDX_MASK 10'd7
`define MIO_IDX_CTRL 10'd8
`define MIO_IDX_AIN1 10'd64
`define MIO_IDX_AIN2 10'd65
`define MIO_IDX_AIN3 10'd66
`define MIO_IDX_CFG 10'd101
`define MIO_IDX_PMSK 10'd104

// configuration word fields
`define MIO_CFG_PUMP_EN 0
`define MIO_CFG_DLY_LO 1
`define MIO_CFG_DLY_HI 3
`define MIO_CFG_DEBUG 4
`define MIO_CFG_SPIN_EN 5
`define MIO_CFG_SPIN_DIR 6
`define MIO_CFG_HW0_EN 7
`define MIO_CFG_HW1_EN 8
`define MIO_CFG_HW_FINE 9
`define MIO_CFG_AIN_EN 10
`define MIO_CFG_DISP_EN 11
`define MIO_CFG_DEFAULT 16'h0F87
`define MIO_PMSK_DEFAULT 16'h0000

// control register bits and speed register direction bit
`define MIO_CTRL_RESET 0
`define MIO_CTRL_KICK 1
`define MIO_SPD_DIR 16

// discrete pin assignment
`define MIO_OUT_SPIN_DIR 2
`define MIO_OUT_PWM 3
`define MIO_OUT_RUN 4
`define MIO_HW0_A 6
`define MIO_HW0_B 7
`define MIO_HW1_A 4
`define MIO_HW1_B 5

// interrupt event bits
`define MIO_EV_W 5
`define MIO_EV_DIN 0
`define MIO_EV_PUMP 1
`define MIO_EV_HW0 2
`define MIO_EV_HW1 3
`define MIO_EV_CFG 4

// non-volatile store slots and default-select code
`define MIO_MEM_CFG 1'b0
`define MIO_MEM_PMSK 1'b1
`define MIO_SEL_DEFAULT 4'h0

// quadrature edges per count
`define MIO_EDGES_FINE 5'd4
`define MIO_EDGES_COARSE 5'd16

// timing
`define MIO_CLK_MHZ 50
`define MIO_PUMP_BASE_US 10000

`endif

// ---- sim/mio_host.sv ----
// host-side bus master model issuing single word transfers
`timescale 1ns/100ps
`default_nettype none
module mio_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task xfer(input logic [9:0] idx, input logic wr, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
endmodule
`default_nettype wire

// ---- sim/mio_top_properties.sv ----
// concurrent checks on the bus, input and output ports of the I/O unit core
`timescale 1ns/100ps
`default_nettype none
module mio_top_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout_ff,
    input wire logic hresp_ff,
    input wire logic [31:0] hrdata_ff,
    input wire logic [7:0] din,
    input wire logic [7:0] dout_ff,
    input wire logic irq_ff
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    wire take = hsel && htrans[1] && hready;
    logic wr_ff;
    logic rd_ff;
    logic cfg_ok_ff;
    logic [9:0] idx_ff;
    logic [15:0] cfg_ff;
    // remembers the last configuration word sent, so read-back can be compared
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            cfg_ok_ff <= 1'b0;
            idx_ff <= 10'h000;
            cfg_ff <= 16'h0000;
        end
        else
        begin
            wr_ff <= take && hwrite;
            rd_ff <= take && !hwrite;
            idx_ff <= haddr[11:2];
            if (wr_ff && idx_ff == 10'd101)
            begin
                cfg_ff <= hwdata[15:0];
                cfg_ok_ff <= 1'b1;
            end
        end
    end
    property p_ready;
        hreadyout_ff && !hresp_ff;
    endproperty
    a_ready: assert property (p_ready) else $error("bus not ready or not okay");
    property p_unmapped;
        take && !hwrite && haddr[11:2] == 10'd9 |=> hrdata_ff == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_din;
        take && !hwrite && haddr[11:2] == 10'd0 && $past(hresetn, 3) && $stable(din)
            && $past(din, 2) == din && $past(din, 3) == din |=> hrdata_ff == {24'h0, $past(din)};
    endproperty
    a_din: assert property (p_din) else $error("input read differs from pins");
    property p_boot;
        $rose(hresetn) |-> dout_ff == 8'h00 [*3];
    endproperty
    a_boot: assert property (p_boot) else $error("outputs active during load");
    property p_nomask;
        wr_ff && idx_ff == 10'd7 && hwdata[4:0] == 5'h00 |-> ##2 !irq_ff;
    endproperty
    a_nomask: assert property (p_nomask) else $error("irq with all masked");
    property p_cfg;
        rd_ff && idx_ff == 10'd101 && cfg_ok_ff |-> hrdata_ff[15:0] == cfg_ff;
    endproperty
    a_cfg: assert property (p_cfg) else $error("stored config read back wrong");
    property p_hold;
        !(take && !hwrite) |=> $stable(hrdata_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_hwtop;
        take && !hwrite && (haddr[11:2] == 10'd2 || haddr[11:2] == 10'd3)
            |=> hrdata_ff[31:16] == 16'h0000;
    endproperty
    a_hwtop: assert property (p_hwtop) else $error("counter upper bits set");
endmodule
bind mio_top mio_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .hrdata_ff(hrdata_ff), .din(din),
    .dout_ff(dout_ff), .irq_ff(irq_ff));
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the I/O unit core
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic hclk;
    logic hresetn;
    logic [7:0] din;
    logic [9:0] analog_in_first;
    logic [9:0] analog_in_second;
    logic [9:0] analog_in_third;
    logic [3:0] cfg_sel;
    int num_errors;
    int cmp_count;
    wire hsel;
    wire hwrite;
    wire hready;
    wire hresp;
    wire irq;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [7:0] dout;
    wire [31:0] haddr;
    wire [31:0] hwdata;
    wire [31:0] hrdata;
    mio_top #(.PUMP_BASE_CYC(32'd20)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout_ff(hready), .hresp_ff(hresp), .hrdata_ff(hrdata),
        .din(din), .analog_in_first(analog_in_first), .analog_in_second(analog_in_second),
        .analog_in_third(analog_in_third), .cfg_sel(cfg_sel), .dout_ff(dout), .irq_ff(irq));
    mio_host i_host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    always #10 hclk = ~hclk;
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task waitc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] q;
        i_host.xfer(idx, 1'b1, d, q);
    endtask
    task rd(input logic [9:0] idx, output logic [31:0] q);
        i_host.xfer(idx, 1'b0, 32'h0, q);
    endtask
    task sreset(input logic [3:0] sel);
        cfg_sel <= sel;
        waitc(4);
        wr(10'd8, 32'h1);
        waitc(8);
    endtask
    task quad(input int lane, input int n);
        logic [7:0] seq;
        // phase b leads phase a: counts up on both wheels
        seq = 8'b10110100;
        for (int c = 0; c < n; c++)
            for (int s = 0; s < 4; s++)
            begin
                @(posedge hclk);
                if (lane == 0)
                    din[7:6] <= seq[7-2*s -: 2];
                else
                    din[5:4] <= seq[7-2*s -: 2];
                waitc(3);
            end
    endtask
    task t_io;
        logic [31:0] q;
        @(posedge hclk);
        din <= 8'hA5;
        waitc(4);
        rd(10'd0, q);
        chk("din", q, 32'hA5);
        rd(10'd9, q);
        chk("unmapped", q, 32'h0);
        wr(10'd1, 32'h5A);
        waitc(2);
        chk("dout", dout, 8'h5A);
        $display("t_io done");
    endtask
    task t_guard;
        logic [31:0] q;
        rd(10'd6, q);
        wr(10'd7, 32'h2);
        wr(10'd1, 32'hC3);
        waitc(60);
        chk("dout before trip", dout, 8'hC3);
        chk("irq before trip", irq, 1'b0);
        waitc(40);
        chk("dout after trip", dout, 8'h00);
        chk("irq after trip", irq, 1'b1);
        rd(10'd6, q);
        chk("trip status", q & 32'h2, 32'h2);
        waitc(3);
        chk("irq cleared", irq, 1'b0);
        wr(10'd7, 32'h0);
        $display("t_guard done");
    endtask
    task t_hw;
        logic [31:0] b0;
        logic [31:0] b1;
        logic [31:0] q;
        logic [15:0] d;
        @(posedge hclk);
        din <= 8'h00;
        quad(0, 1);
        quad(1, 1);
        rd(10'd2, b0);
        rd(10'd3, b1);
        quad(0, 2);
        rd(10'd2, q);
        d = q[15:0] - b0[15:0];
        chk("hw0 two cycles", d, 16'h0002);
        rd(10'd3, q);
        chk("hw1 untouched", q, b1);
        quad(1, 1);
        rd(10'd3, q);
        d = q[15:0] - b1[15:0];
        chk("hw1 one cycle", d, 16'h0001);
        $display("t_hw done");
    endtask
    task t_ain;
        logic [31:0] q;
        logic [9:0] exp [3];
        exp = '{10'h000, 10'h3FF, 10'h155};
        for (int i = 0; i < 3; i++)
        begin
            rd(10'd64 + i[9:0], q);
            chk("analog", q, {22'h0, exp[i]});
        end
        $display("t_ain done");
    endtask
    task t_cfg;
        logic [31:0] q;
        wr(10'd101, 32'h0F81);
        rd(10'd101, q);
        chk("cfg stored", q[15:0], 16'h0F81);
        wr(10'd104, 32'h0F);
        wr(10'd1, 32'hFF);
        waitc(40);
        chk("old config kept", dout, 8'hFF);
        sreset(4'h1);
        wr(10'd1, 32'hFF);
        waitc(2);
        chk("new config out", dout, 8'hFF);
        waitc(40);
        chk("masked guard", dout, 8'h0F);
        wr(10'd101, 32'h0F97);
        sreset(4'h1);
        wr(10'd1, 32'hFF);
        waitc(2);
        chk("debug off", dout, 8'h00);
        sreset(4'h0);
        wr(10'd1, 32'h33);
        waitc(2);
        chk("defaults", dout, 8'h33);
        $display("t_cfg done");
    endtask
    // high cycles of the pwm pin over one period of eight
    task duty(output logic [31:0] n);
        n = 32'h0;
        repeat (8)
        begin
            @(posedge hclk);
            n = n + dout[3];
        end
    endtask
    task t_spin;
        logic [31:0] n;
        wr(10'd101, 32'h0FE0);
        sreset(4'h1);
        wr(10'd5, 32'h8);
        wr(10'd4, 32'h1_0004);
        waitc(2);
        duty(n);
        chk("pwm half", n, 32'h4);
        chk("spindle pins", dout & 8'h14, 8'h14);
        wr(10'd1, 32'hFF);
        wr(10'd4, 32'h8);
        waitc(2);
        duty(n);
        chk("pwm full", n, 32'h8);
        wr(10'd4, 32'h0);
        waitc(2);
        chk("claimed pins", dout, 8'hE3);
        $display("t_spin done");
    endtask
    initial
    begin
        #200000;
        num_errors++;
        end_sim;
    end
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        din = 8'h00;
        analog_in_first = 10'h000;
        analog_in_second = 10'h3FF;
        analog_in_third = 10'h155;
        cfg_sel = 4'h0;
        num_errors = 0;
        cmp_count = 0;
        waitc(10);
        hresetn <= 1'b1;
        waitc(6);
        t_io;
        t_guard;
        t_hw;
        t_ain;
        t_cfg;
        t_spin;
        end_sim;
    end
endmodule
`default_nettype wire
